// ==== hw/sss_cfg.svh ====
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// ********************************
// clock and timing
// ********************************
`define SSS_CLK_HZ          125000000
`define SSS_MS_PER_S        1000
`define SSS_CYC_PER_MS      (`SSS_CLK_HZ / `SSS_MS_PER_S)
`define SSS_SPEED_EARLY_S   3
`define SSS_SPEED_LATE_S    15
`define SSS_SPEED_EARLY_MS  (`SSS_SPEED_EARLY_S * `SSS_MS_PER_S)
`define SSS_SPEED_LATE_MS   (`SSS_SPEED_LATE_S * `SSS_MS_PER_S)
`define SSS_LOCK_SETTLE_MS  100
`define SSS_MAX_START_TRIES 2'd3
`define SSS_MAX_CYL         10'd822

// ********************************
// register map (byte addresses)
// ********************************
`define SSS_OFF_CTRL        8'h00
`define SSS_OFF_SEEK        8'h04
`define SSS_OFF_CMD         8'h08
`define SSS_OFF_STAT        8'h0C
`define SSS_CTRL_START      0
`define SSS_CTRL_SEQ_HOLD   1
`define SSS_CTRL_POST_FAIL  2
`define SSS_CTRL_DUMMY_RTZ  3
`define SSS_CTRL_DUMMY_HANG 4
`define SSS_CMD_RTZ         0
`define SSS_CMD_FCLR        1
`define SSS_CTRL_RST        5'h00
`define SSS_SEEK_RST        10'h000

// ********************************
// status codes
// ********************************
`define SSS_C_UNLOAD        8'h01
`define SSS_C_BRAKE         8'h02
`define SSS_C_STOPPED       8'h03
`define SSS_C_NO_PACK       8'h04
`define SSS_C_DOOR_STUCK    8'h05
`define SSS_C_NO_LOCK       8'h06
`define SSS_C_HEADS_OUT     8'h07
`define SSS_C_STARTING      8'h08
`define SSS_C_SPEED_SOON    8'h09
`define SSS_C_RETRY         8'h0A
`define SSS_C_RETRY_SENS    8'h0B
`define SSS_C_FAIL          8'h0C
`define SSS_C_FAIL_SENS     8'h0D
`define SSS_C_LOAD_N        8'h20
`define SSS_C_LOAD_F        8'hA0
`define SSS_C_RTZ_N         8'h30
`define SSS_C_RTZ_F         8'hB0
`define SSS_C_GUARD_N       8'h40
`define SSS_C_GUARD_F       8'hC0
`define SSS_C_SEEKTO_N      8'h46
`define SSS_C_SEEKTO_F      8'hC6
`define SSS_C_ONCYL_N       8'h47
`define SSS_C_ONCYL_F       8'hC7
`define SSS_C_OFFCYL_N      8'h4B
`define SSS_C_OFFCYL_F      8'hCB
`define SSS_C_DEMLOST_N     8'h4C
`define SSS_C_DEMLOST_F     8'hCC
`define SSS_C_VFAULT_N      8'h4E
`define SSS_C_VFAULT_F      8'hCE
`define SSS_C_ILLCYL_N      8'h4D
`define SSS_C_ILLCYL_F      8'hCD
`define SSS_C_LOW_VCC       8'hD0
`define SSS_C_HANG          8'hD1
`define SSS_C_POST_FAIL     8'hFF
`define SSS_MAX_LOAD_IDX    4'hD
`define SSS_MAX_RTZ_IDX     4'h9
`define SSS_MAX_GUARD_IDX   4'h5
`define SSS_MAX_ONCYL_IDX   4'h3

`endif

// ==== hw/sss_pkg.sv ====
package sss_pkg;

    typedef enum logic [3:0] {
        ST_STOPPED, ST_UNLOAD, ST_BRAKE, ST_PACK, ST_UNLOCK, ST_LOCK, ST_HEADS,
        ST_SPIN, ST_RETRY, ST_FAIL, ST_HALT, ST_LOAD, ST_READY, ST_SEEK, ST_ERR
    } sss_state_t;

    typedef enum logic [2:0] {
        ERR_LOAD, ERR_RTZ, ERR_GUARD, ERR_SEEKTO, ERR_ONCYL, ERR_ONTRK
    } sss_err_t;

endpackage

// ==== hw/sss_seq.sv ====
`timescale 1ns/100ps
`include "sss_cfg.svh"

module sss_seq #(
    parameter int CYC_PER_MS    = `SSS_CYC_PER_MS,
    parameter int EARLY_MS      = `SSS_SPEED_EARLY_MS,
    parameter int LATE_MS       = `SSS_SPEED_LATE_MS,
    parameter int LOCK_SETTLE   = `SSS_LOCK_SETTLE_MS
) (
    input  wire logic             REF_CLK_I,
    input  wire logic             RST_I,
    input  wire logic             HSEL_I,
    input  wire logic [31:0]      HADDR_I,
    input  wire logic [1:0]       HTRANS_I,
    input  wire logic             HWRITE_I,
    input  wire logic [2:0]       HSIZE_I,
    input  wire logic [31:0]      HWDATA_I,
    input  wire logic             HREADY_I,
    output logic      [31:0]      HRDATA_O,
    output logic                  HREADYOUT_O,
    output logic                  HRESP_O,
    input  wire logic             PACK_PRESENT_I,
    input  wire logic             DOOR_LOCKED_I,
    input  wire logic             HEADS_LOADED_I,
    input  wire logic             SPINDLE_AT_SPEED_I,
    input  wire logic             SPEED_SENSOR_FAULT_I,
    input  wire logic             MOTOR_STOPPED_I,
    input  wire logic             ON_CYL_I,
    input  wire logic             SERVO_ERR_I,
    input  wire sss_pkg::sss_err_t SERVO_ERR_CLASS_I,
    input  wire logic [3:0]       SERVO_ERR_IDX_I,
    input  wire logic             PRIOR_FAULT_I,
    output logic                  MOTOR_RUN_O,
    output logic                  BRAKE_O,
    output logic                  DOOR_LOCK_O,
    output logic                  HEAD_RETRACT_O,
    output logic                  SEEK_REQ_O,
    output logic      [9:0]       SEEK_CYL_O,
    output logic      [7:0]       STATUS_CODE_O
);
    import sss_pkg::*;

    sss_tmr_if tmr ();

    sss_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer (
        .REF_CLK_I (REF_CLK_I),
        .RST_I     (RST_I),
        .t         (tmr.timer)
    );

    sss_state_t  state;
    logic [4:0]  ctrl;
    logic [9:0]  seek_cyl;
    logic [7:0]  seq_code;
    logic [7:0]  dest_code;
    logic [1:0]  tries;
    logic        sens_fault;
    logic        seek_go;
    logic        rtz_cmd;
    logic        fclr;
    logic        dph_wr;
    logic [7:0]  dph_addr;
    logic        start_sw;
    logic        seq_hold;
    logic        settled;
    logic [15:0] ms_now;

    assign start_sw = ctrl[`SSS_CTRL_START];
    assign seq_hold = ctrl[`SSS_CTRL_SEQ_HOLD];
    // the timer clears one edge after the request; hide its stale count meanwhile
    assign ms_now   = tmr.clr ? 16'h0000 : tmr.ms;
    assign settled  = (ms_now >= 16'(LOCK_SETTLE));

    // ********************************
    // error code lookup
    // ********************************
    function automatic logic [7:0] err_code(input sss_err_t cls, input logic [3:0] idx,
                                            input logic prior);
        logic [3:0] i;
        i = idx;
        err_code = prior ? `SSS_C_SEEKTO_F : `SSS_C_SEEKTO_N;
        case (cls)
            ERR_LOAD: begin
                if (i > `SSS_MAX_LOAD_IDX) i = `SSS_MAX_LOAD_IDX;
                err_code = (prior ? `SSS_C_LOAD_F : `SSS_C_LOAD_N) + {4'h0, i};
            end
            ERR_RTZ: begin
                if (i > `SSS_MAX_RTZ_IDX) i = `SSS_MAX_RTZ_IDX;
                err_code = (prior ? `SSS_C_RTZ_F : `SSS_C_RTZ_N) + {4'h0, i};
            end
            ERR_GUARD: begin
                if (i > `SSS_MAX_GUARD_IDX) i = `SSS_MAX_GUARD_IDX;
                err_code = (prior ? `SSS_C_GUARD_F : `SSS_C_GUARD_N) + {4'h0, i};
            end
            ERR_SEEKTO: begin
                err_code = prior ? `SSS_C_SEEKTO_F : `SSS_C_SEEKTO_N;
            end
            ERR_ONCYL: begin
                if (i > `SSS_MAX_ONCYL_IDX) i = `SSS_MAX_ONCYL_IDX;
                err_code = (prior ? `SSS_C_ONCYL_F : `SSS_C_ONCYL_N) + {4'h0, i};
            end
            ERR_ONTRK: begin
                // off cylinder, demodulator lost, voltage fault; 4D/CD skipped here
                case (i)
                    4'h0:    err_code = prior ? `SSS_C_OFFCYL_F : `SSS_C_OFFCYL_N;
                    4'h1:    err_code = prior ? `SSS_C_DEMLOST_F : `SSS_C_DEMLOST_N;
                    default: err_code = prior ? `SSS_C_VFAULT_F : `SSS_C_VFAULT_N;
                endcase
            end
            default: err_code = prior ? `SSS_C_SEEKTO_F : `SSS_C_SEEKTO_N;
        endcase
    endfunction

    // ********************************
    // AHB-Lite slave, zero wait states
    // ********************************
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            dph_wr   <= 1'b0;
            dph_addr <= 8'h00;
            HRDATA_O <= 32'h0000_0000;
        end else begin
            dph_wr <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
            if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
                dph_addr <= HADDR_I[7:0];
            end
            if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I) begin
                case (HADDR_I[7:0])
                    `SSS_OFF_CTRL: HRDATA_O <= {27'h0, ctrl};
                    `SSS_OFF_SEEK: HRDATA_O <= {22'h0, seek_cyl};
                    `SSS_OFF_STAT: HRDATA_O <= {12'h0, HEAD_RETRACT_O, DOOR_LOCK_O, BRAKE_O,
                                                MOTOR_RUN_O, 2'b00, tries, state,
                                                STATUS_CODE_O};
                    default:       HRDATA_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            ctrl     <= `SSS_CTRL_RST;
            seek_cyl <= `SSS_SEEK_RST;
            seek_go  <= 1'b0;
            rtz_cmd  <= 1'b0;
            fclr     <= 1'b0;
        end else begin
            seek_go <= dph_wr && dph_addr == `SSS_OFF_SEEK;
            rtz_cmd <= dph_wr && dph_addr == `SSS_OFF_CMD && HWDATA_I[`SSS_CMD_RTZ];
            fclr    <= dph_wr && dph_addr == `SSS_OFF_CMD && HWDATA_I[`SSS_CMD_FCLR];
            if (dph_wr && dph_addr == `SSS_OFF_CTRL) begin
                ctrl <= HWDATA_I[4:0];
            end
            if (dph_wr && dph_addr == `SSS_OFF_SEEK) begin
                seek_cyl <= HWDATA_I[9:0];
            end
        end
    end

    // ********************************
    // spindle and seek sequencer
    // ********************************
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state          <= ST_STOPPED;
            seq_code       <= `SSS_C_STOPPED;
            dest_code      <= 8'h00;
            tries          <= 2'd0;
            sens_fault     <= 1'b0;
            MOTOR_RUN_O    <= 1'b0;
            BRAKE_O        <= 1'b0;
            DOOR_LOCK_O    <= 1'b0;
            HEAD_RETRACT_O <= 1'b0;
            SEEK_REQ_O     <= 1'b0;
            SEEK_CYL_O     <= 10'h000;
            tmr.clr        <= 1'b1;
        end else begin
            SEEK_REQ_O <= 1'b0;
            tmr.clr    <= 1'b0;
            case (state)
                ST_STOPPED: begin
                    DOOR_LOCK_O <= 1'b0;
                    BRAKE_O     <= 1'b0;
                    if (start_sw && seq_hold) begin
                        tries <= 2'd0;
                        state <= ST_PACK;
                    end
                end
                ST_PACK: begin
                    if (!PACK_PRESENT_I) begin
                        seq_code <= `SSS_C_NO_PACK;
                        state    <= ST_HALT;
                    end else begin
                        DOOR_LOCK_O <= 1'b0;
                        tmr.clr     <= 1'b1;
                        state       <= ST_UNLOCK;
                    end
                end
                ST_UNLOCK: begin
                    // let the solenoid release before trusting the switch
                    if (settled) begin
                        if (DOOR_LOCKED_I) begin
                            seq_code <= `SSS_C_DOOR_STUCK;
                            state    <= ST_HALT;
                        end else begin
                            DOOR_LOCK_O <= 1'b1;
                            tmr.clr     <= 1'b1;
                            state       <= ST_LOCK;
                        end
                    end
                end
                ST_LOCK: begin
                    if (settled) begin
                        if (!DOOR_LOCKED_I) begin
                            seq_code <= `SSS_C_NO_LOCK;
                            state    <= ST_HALT;
                        end else begin
                            state <= ST_HEADS;
                        end
                    end
                end
                ST_HEADS: begin
                    if (HEADS_LOADED_I) begin
                        seq_code <= `SSS_C_HEADS_OUT;
                        state    <= ST_HALT;
                    end else begin
                        seq_code    <= `SSS_C_STARTING;
                        MOTOR_RUN_O <= 1'b1;
                        BRAKE_O     <= 1'b0;
                        tmr.clr     <= 1'b1;
                        state       <= ST_SPIN;
                    end
                end
                ST_SPIN: begin
                    if (SPINDLE_AT_SPEED_I && ms_now < 16'(EARLY_MS)) begin
                        seq_code    <= `SSS_C_SPEED_SOON;
                        MOTOR_RUN_O <= 1'b0;
                        BRAKE_O     <= 1'b1;
                        state       <= ST_HALT;
                    end else if (SPINDLE_AT_SPEED_I) begin
                        SEEK_CYL_O <= 10'h000;
                        SEEK_REQ_O <= 1'b1;
                        state      <= ST_LOAD;
                    end else if (ms_now >= 16'(LATE_MS)) begin
                        MOTOR_RUN_O <= 1'b0;
                        BRAKE_O     <= 1'b1;
                        sens_fault  <= SPEED_SENSOR_FAULT_I;
                        tries       <= tries + 2'd1;
                        if (tries + 2'd1 >= `SSS_MAX_START_TRIES) begin
                            seq_code <= SPEED_SENSOR_FAULT_I ? `SSS_C_FAIL_SENS
                                                             : `SSS_C_FAIL;
                            state    <= ST_FAIL;
                        end else begin
                            seq_code <= SPEED_SENSOR_FAULT_I ? `SSS_C_RETRY_SENS
                                                             : `SSS_C_RETRY;
                            state    <= ST_RETRY;
                        end
                    end
                end
                ST_RETRY: begin
                    if (MOTOR_STOPPED_I) begin
                        seq_code    <= `SSS_C_STARTING;
                        BRAKE_O     <= 1'b0;
                        MOTOR_RUN_O <= 1'b1;
                        tmr.clr     <= 1'b1;
                        state       <= ST_SPIN;
                    end
                end
                ST_FAIL, ST_HALT: begin
                    // only a start switch cycle re-arms; brake held only until the motor stops or the switch drops
                    if (MOTOR_STOPPED_I) begin
                        BRAKE_O <= 1'b0;
                    end
                    if (!start_sw && (MOTOR_STOPPED_I || !MOTOR_RUN_O)) begin
                        DOOR_LOCK_O <= 1'b0;
                        BRAKE_O     <= 1'b0;
                        MOTOR_RUN_O <= 1'b0;
                        seq_code    <= `SSS_C_STOPPED;
                        state       <= ST_STOPPED;
                    end
                end
                ST_LOAD, ST_SEEK, ST_READY, ST_ERR: begin
                    if (!start_sw) begin
                        seq_code       <= `SSS_C_UNLOAD;
                        HEAD_RETRACT_O <= 1'b1;
                        state          <= ST_UNLOAD;
                    end else if (SERVO_ERR_I && state != ST_ERR) begin
                        seq_code <= err_code(SERVO_ERR_CLASS_I, SERVO_ERR_IDX_I,
                                             PRIOR_FAULT_I);
                        state    <= ST_ERR;
                    end else if (state == ST_ERR) begin
                        if (rtz_cmd) begin
                            SEEK_CYL_O <= 10'h000;
                            SEEK_REQ_O <= 1'b1;
                            state      <= ST_SEEK;
                        end else if (fclr) begin
                            seq_code <= dest_code;
                            state    <= ST_READY;
                        end
                    end else if (state == ST_READY && (seek_go || rtz_cmd)) begin
                        if (seek_go && seek_cyl > `SSS_MAX_CYL) begin
                            seq_code <= PRIOR_FAULT_I ? `SSS_C_ILLCYL_F
                                                      : `SSS_C_ILLCYL_N;
                            state    <= ST_ERR;
                        end else begin
                            SEEK_CYL_O <= seek_go ? seek_cyl : 10'h000;
                            SEEK_REQ_O <= 1'b1;
                            state      <= ST_SEEK;
                        end
                    end else if (state != ST_READY && ON_CYL_I && !SEEK_REQ_O) begin
                        dest_code <= SEEK_CYL_O[9:2];
                        seq_code  <= SEEK_CYL_O[9:2];
                        state     <= ST_READY;
                    end
                end
                ST_UNLOAD: begin
                    // no timeout: motor keeps running until retract is seen
                    if (!HEADS_LOADED_I) begin
                        HEAD_RETRACT_O <= 1'b0;
                        MOTOR_RUN_O    <= 1'b0;
                        BRAKE_O        <= 1'b1;
                        seq_code       <= `SSS_C_BRAKE;
                        state          <= ST_BRAKE;
                    end
                end
                ST_BRAKE: begin
                    if (MOTOR_STOPPED_I) begin
                        BRAKE_O     <= 1'b0;
                        DOOR_LOCK_O <= 1'b0;
                        seq_code    <= `SSS_C_STOPPED;
                        state       <= ST_STOPPED;
                    end
                end
                default: begin
                    state <= ST_STOPPED;
                end
            endcase
        end
    end

    // ********************************
    // display
    // ********************************
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            STATUS_CODE_O <= `SSS_C_STOPPED;
        end else if (ctrl[`SSS_CTRL_POST_FAIL]) begin
            STATUS_CODE_O <= `SSS_C_POST_FAIL;
        end else if (ctrl[`SSS_CTRL_DUMMY_RTZ]) begin
            STATUS_CODE_O <= ctrl[`SSS_CTRL_DUMMY_HANG] ? `SSS_C_HANG
                                                         : `SSS_C_LOW_VCC;
        end else begin
            STATUS_CODE_O <= seq_code;
        end
    end
endmodule

// ==== hw/sss_timer.sv ====
`timescale 1ns/100ps

module sss_timer #(
    parameter int CYC_PER_MS = 125000
) (
    input  wire logic REF_CLK_I,
    input  wire logic RST_I,
    sss_tmr_if.timer  t
);
    localparam int DW = $clog2(CYC_PER_MS + 1);

    logic [DW-1:0] div;
    logic          tick;

    // ********************************
    // millisecond enable
    // ********************************
    assign tick = (div == DW'(CYC_PER_MS - 1));

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || t.clr || tick) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    // saturates so a stuck sensor never wraps back into the early window
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || t.clr) begin
            t.ms <= 16'h0000;
        end else if (tick && t.ms != 16'hFFFF) begin
            t.ms <= t.ms + 16'h0001;
        end
    end
endmodule

// ==== hw/sss_tmr_if.sv ====
`timescale 1ns/100ps

interface sss_tmr_if;
    logic        clr;
    logic [15:0] ms;

    modport seq   (output clr, input ms);
    modport timer (input clr, output ms);
endinterface

// ==== verification/sss_drive_model.sv ====
`timescale 1ns/100ps
module sss_drive_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic       lock_i,
    input  wire logic       retract_i,
    input  wire logic       seek_i,
    input  wire logic [1:0] mode_i,
    input  wire logic [7:0] spin_i,
    output logic            locked_o,
    output logic            loaded_o,
    output logic            at_speed_o,
    output logic            stopped_o,
    output logic            on_cyl_o
);
    int run_cnt, idle_cnt, seek_cnt;
    // spin_i zero: motor never reaches speed; mode 1..3 jam door or heads
    always_ff @(posedge clk_i) begin
        run_cnt <= (rst_i || !run_i) ? 0 : run_cnt + 1;
        idle_cnt <= (rst_i || run_i) ? 0 : idle_cnt + 1;
        seek_cnt <= (rst_i || seek_i) ? 0 : seek_cnt + 1;
        locked_o <= (lock_i && mode_i != 2'h2) || mode_i == 2'h1;
        loaded_o <= (run_i && !retract_i && at_speed_o) || mode_i == 2'h3;
        at_speed_o <= spin_i != 8'h00 && run_cnt >= spin_i;
        // the spindle coasts a while after the drive is removed
        stopped_o <= idle_cnt >= 10;
        on_cyl_o <= !seek_i && seek_cnt >= 6;
    end
endmodule

// ==== verification/sss_seq_asserts.sv ====
`timescale 1ns/100ps
module sss_seq_asserts (
    input wire logic       REF_CLK_I,
    input wire logic       RST_I,
    input wire logic       MOTOR_RUN_O,
    input wire logic       BRAKE_O,
    input wire logic       DOOR_LOCK_O,
    input wire logic       SEEK_REQ_O,
    input wire logic [9:0] SEEK_CYL_O,
    input wire logic [7:0] STATUS_CODE_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    AST_RESET_CODE:
        assert property ($fell(RST_I) |-> STATUS_CODE_O == 8'h03) else $error("no 03");
    AST_HALT_IDLE:
        assert property (STATUS_CODE_O inside {[8'h04:8'h07]} |-> !MOTOR_RUN_O) else $error("run");
    AST_UNLOCK_LOW:
        assert property (STATUS_CODE_O == 8'h05 |-> !DOOR_LOCK_O) else $error("lock at 05");
    AST_SPIN_WAIT:
        assert property ($changed(STATUS_CODE_O) && STATUS_CODE_O inside {[8'h0A:8'h0D]}
            |-> $past(STATUS_CODE_O, 2) == 8'h08) else $error("start given up at once");
    AST_UNLOAD_RUN:
        assert property ((STATUS_CODE_O == 8'h01) [*2] |-> $past(MOTOR_RUN_O) && !$past(BRAKE_O))
            else $error("01 without motor");
    AST_BRAKE_STOP:
        assert property ((STATUS_CODE_O == 8'h02) [*2] |-> $past(BRAKE_O) && !$past(MOTOR_RUN_O))
            else $error("02 without brake");
    AST_SPIN_RUN:
        assert property ((STATUS_CODE_O == 8'h08) [*2] |-> $past(MOTOR_RUN_O)) else $error("08 idle");
    AST_STOP_IDLE:
        assert property ((STATUS_CODE_O == 8'h03) [*2] |-> !$past(MOTOR_RUN_O)) else $error("03 run");
    AST_SEEK_LEGAL:
        assert property (SEEK_REQ_O |-> SEEK_CYL_O <= 10'h336) else $error("illegal seek");
    AST_ERR_HOLD:
        assert property ($changed(STATUS_CODE_O) && STATUS_CODE_O inside {[8'hA0:8'hCE]}
            |=> $stable(STATUS_CODE_O)) else $error("error code dropped");
    cover property (STATUS_CODE_O == 8'h00);
    cover property (STATUS_CODE_O == 8'h0D);
    cover property (STATUS_CODE_O == 8'hCD);
endmodule

bind sss_seq sss_seq_asserts u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
    .MOTOR_RUN_O(MOTOR_RUN_O), .BRAKE_O(BRAKE_O), .DOOR_LOCK_O(DOOR_LOCK_O),
    .SEEK_REQ_O(SEEK_REQ_O), .SEEK_CYL_O(SEEK_CYL_O), .STATUS_CODE_O(STATUS_CODE_O));

// ==== verification/sss_seq_bench.sv ====
`timescale 1ns/100ps
module sss_seq_bench;
    import sss_pkg::*;
    logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, pack = 1'h1, sens = 1'h0;
    logic serr = 1'h0, prior = 1'h0, hrdy, hresp, run, brake, lock, retr, sreq;
    logic locked, loaded, speed, stopped, oncyl;
    logic [1:0]  htrans = 2'h0, stuck = 2'h0;
    logic [3:0]  eidx = 4'h0;
    logic [7:0]  haddr = 8'h00, code, spin = 8'h00;
    logic [9:0]  scyl;
    logic [31:0] hwdata = 32'h0, hrdata, rdv;
    sss_err_t    ecls = ERR_LOAD;
    int          fail_count = 0, total_checks = 0;
    sss_seq #(.CYC_PER_MS(4), .EARLY_MS(5), .LATE_MS(20), .LOCK_SETTLE(2)) dut (
        .REF_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I({24'h0, haddr}), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
        .HREADYOUT_O(hrdy), .HRESP_O(hresp), .PACK_PRESENT_I(pack), .DOOR_LOCKED_I(locked),
        .HEADS_LOADED_I(loaded), .SPINDLE_AT_SPEED_I(speed), .SPEED_SENSOR_FAULT_I(sens),
        .MOTOR_STOPPED_I(stopped), .ON_CYL_I(oncyl), .SERVO_ERR_I(serr), .SERVO_ERR_CLASS_I(ecls),
        .SERVO_ERR_IDX_I(eidx), .PRIOR_FAULT_I(prior), .MOTOR_RUN_O(run), .BRAKE_O(brake),
        .DOOR_LOCK_O(lock), .HEAD_RETRACT_O(retr), .SEEK_REQ_O(sreq), .SEEK_CYL_O(scyl),
        .STATUS_CODE_O(code));
    sss_drive_model model (.clk_i(clk), .rst_i(rst), .run_i(run), .lock_i(lock), .retract_i(retr),
        .seek_i(sreq), .mode_i(stuck), .spin_i(spin), .locked_o(locked), .loaded_o(loaded),
        .at_speed_o(speed), .stopped_o(stopped), .on_cyl_o(oncyl));
    initial begin
        forever #4 clk = ~clk;
    end
    task end_sim;
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'h1);
        rdv = hrdata;
    endtask
    task wc(input logic [7:0] want);
        int n;
        n = 0;
        while (code !== want && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk(code, want);
    endtask
    task halt(input logic [7:0] want);
        bus(1'h1, 8'h00, 32'h3);
        wc(want);
        bus(1'h1, 8'h00, 32'h0);
        wc(8'h03);
    endtask
    // expected fault display: class base plus clamped index, top bit for earlier fault
    function automatic logic [7:0] ecode(input int c, input int i, input bit f);
        int mx[6] = '{13, 9, 5, 0, 3, 2};
        logic [7:0] base[6] = '{8'h20, 8'h30, 8'h40, 8'h46, 8'h47, 8'h4B};
        if (i > mx[c]) i = mx[c];
        if (c == 5 && i == 2) i = 3;
        ecode = base[c] + 8'(i);
        if (f) ecode[7] = 1'h1;
    endfunction
    initial begin
        #(8 * 40000);
        fail_count++;
        end_sim;
    end
    initial begin
        void'($urandom(32698));
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk(code, 8'h03);
        for (int h = 1; h < 3; h++) begin
            bus(1'h1, 8'h00, 32'(h));
            repeat (20) @(posedge clk);
            chk(code, 8'h03);
        end
        pack <= 1'h0;
        halt(8'h04);
        pack <= 1'h1;
        for (int m = 1; m < 4; m++) begin
            stuck <= 2'(m);
            halt(8'(4 + m));
        end
        stuck <= 2'h0;
        spin <= 8'h08;
        halt(8'h09);
        spin <= 8'h00;
        for (int f = 0; f < 2; f++) begin
            sens <= 1'(f);
            bus(1'h1, 8'h00, 32'h3);
            repeat (2) begin
                wc(8'h08);
                wc(8'(10 + f));
            end
            wc(8'h08);
            wc(8'(12 + f));
            bus(1'h1, 8'h00, 32'h0);
            wc(8'h03);
        end
        spin <= 8'h28;
        bus(1'h1, 8'h00, 32'h3);
        wc(8'h08);
        wc(8'h00);
        bus(1'h1, 8'h04, 32'h1FF);
        wc(8'h7F);
        prior <= 1'h1;
        bus(1'h1, 8'h04, 32'h337);
        wc(8'hCD);
        repeat (10) @(posedge clk);
        chk(code, 8'hCD);
        bus(1'h1, 8'h08, 32'h2);
        wc(8'h7F);
        for (int c = 0; c < 6; c++) begin
            ecls <= sss_err_t'(c);
            eidx <= 4'($urandom_range(15));
            prior <= 1'($urandom_range(1));
            serr <= 1'h1;
            @(posedge clk);
            serr <= 1'h0;
            wc(ecode(c, eidx, prior));
            bus(1'h0, 8'h0C, 32'h0);
            chk(rdv[7:0], ecode(c, eidx, prior));
            // even passes clear by return to zero, odd by fault clear; both land on 00
            bus(1'h1, 8'h08, 32'(1 + c % 2));
            wc(8'h00);
        end
        bus(1'h1, 8'h00, 32'h7);
        wc(8'hFF);
        for (int k = 0; k < 2; k++) begin
            bus(1'h1, 8'h00, 32'(8'h0B + 16 * k));
            wc(8'(8'hD0 + k));
        end
        bus(1'h0, 8'h10, 32'h0);
        chk(rdv, 32'h0);
        bus(1'h1, 8'h00, 32'h0);
        wc(8'h01);
        wc(8'h02);
        wc(8'h03);
        end_sim;
    end
endmodule
